/* core/rif_top.sv */
// Radio interrupt flags: eight latched event flags with mask, the CPU-level
// radio flag, the per-byte data-register flag and a summary interrupt.
// Assumes a single 100 MHz clock, synchronous inputs and a plain register port
// whose read data appear one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none

module rif_top (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire rif_pkg::rif_evt_t evt_cond_i,
  input wire rif_pkg::rif_dreg_t dreg_evt_i,
  output logic data_byte_irq_o,
  output logic radio_irq_o,
  output logic irq_o
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Write-zero clear with set winning over a same-cycle clear
  function automatic logic [7:0] w0c_update(input logic [7:0] cur, input logic hit,
                                            input logic [7:0] wdata, input logic [7:0] set);
    logic [7:0] kept;
    kept = hit ? (cur & wdata) : cur;
    return kept | set;
  endfunction : w0c_update

  // Register select for a write or read strobe
  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
                                   input logic [7:0] offset);
    return strobe && (addr == offset);
  endfunction : reg_hit

  // ************************************************************
  // State declarations
  // ************************************************************
  rif_pkg::rif_evt_t cond_prev_q;
  rif_pkg::rif_evt_t cond_prev_d;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic cpu_flag_q;
  logic cpu_flag_d;
  logic radio_en_q;
  logic radio_en_d;
  logic db_flag_q;
  logic db_flag_d;
  logic db_en_q;
  logic db_en_d;
  rif_pkg::rif_db_state_t db_state_q;
  rif_pkg::rif_db_state_t db_state_d;
  logic [1:0] stat_q;
  logic [1:0] stat_d;
  logic [1:0] imask_q;
  logic [1:0] imask_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic db_irq_q;
  logic db_irq_d;
  logic radio_irq_q;
  logic radio_irq_d;
  logic irq_q;
  logic irq_d;

  // Decoded strobes
  logic wr_flags;
  logic wr_mask;
  logic wr_tctl;
  logic wr_en0;
  logic wr_en2;
  logic wr_cpu;
  logic wr_imask;
  logic rd_stat;
  logic [7:0] evt_set;
  logic db_set;
  logic cpu_set;

  // ************************************************************
  // Register port decode
  // ************************************************************

  // Write and read selects
  always_comb begin
    wr_flags = reg_hit(reg_wr_i, reg_addr_i, rif_pkg::RIF_ADDR_EVENT_FLAGS);
    wr_mask = reg_hit(reg_wr_i, reg_addr_i, rif_pkg::RIF_ADDR_EVENT_MASK);
    wr_tctl = reg_hit(reg_wr_i, reg_addr_i, rif_pkg::RIF_ADDR_TIMER_CTL);
    wr_en0 = reg_hit(reg_wr_i, reg_addr_i, rif_pkg::RIF_ADDR_IRQ_EN_ZERO);
    wr_en2 = reg_hit(reg_wr_i, reg_addr_i, rif_pkg::RIF_ADDR_IRQ_EN_TWO);
    wr_cpu = reg_hit(reg_wr_i, reg_addr_i, rif_pkg::RIF_ADDR_CPU_RADIO_FLAG);
    wr_imask = reg_hit(reg_wr_i, reg_addr_i, rif_pkg::RIF_ADDR_IRQ_MASK);
    rd_stat = reg_hit(reg_rd_i, reg_addr_i, rif_pkg::RIF_ADDR_IRQ_STATUS);
  end

  // ************************************************************
  // Radio event flags and mask
  // ************************************************************

  // Edge detect, overflow and underflow drag packet done along
  always_comb begin
    cond_prev_d = evt_cond_i;
    evt_set = evt_cond_i & ~cond_prev_q;
    if (evt_set[rif_pkg::RIF_BIT_TX_UNDERFLOW] || evt_set[rif_pkg::RIF_BIT_RX_OVERFLOW]) begin
      evt_set[rif_pkg::RIF_BIT_PACKET_DONE] = 1'b1;
    end
    flags_d = w0c_update(flags_q, wr_flags, reg_wdata_i, evt_set);
    mask_d = wr_mask ? reg_wdata_i : mask_q;
  end

  // Event flag registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cond_prev_q <= rif_pkg::RIF_RST_EVENT_FLAGS;
      flags_q <= rif_pkg::RIF_RST_EVENT_FLAGS;
      mask_q <= rif_pkg::RIF_RST_EVENT_MASK;
    end else begin
      cond_prev_q <= cond_prev_d;
      flags_q <= flags_d;
      mask_q <= mask_d;
    end
  end

  // ************************************************************
  // CPU-level radio flag and its enable
  // ************************************************************

  // Sticky flag set by any masked new event
  always_comb begin
    cpu_set = |(evt_set & mask_q);
    cpu_flag_d = cpu_flag_q;
    if (wr_cpu && !reg_wdata_i[rif_pkg::RIF_BIT_CPU_RADIO_FLAG]) begin
      cpu_flag_d = 1'b0;
    end
    if (cpu_set) begin
      cpu_flag_d = 1'b1;
    end
    radio_en_d = wr_en2 ? reg_wdata_i[rif_pkg::RIF_BIT_RADIO_IRQ_ENABLE] : radio_en_q;
  end

  // CPU flag registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cpu_flag_q <= rif_pkg::RIF_RST_BIT;
      radio_en_q <= rif_pkg::RIF_RST_BIT;
    end else begin
      cpu_flag_q <= cpu_flag_d;
      radio_en_q <= radio_en_d;
    end
  end

  // ************************************************************
  // Data-byte flag sequencing
  // ************************************************************

  // Transmit arming, status byte two, flag set and clear
  always_comb begin
    db_state_d = db_state_q;
    db_set = 1'b0;
    case (db_state_q)
      rif_pkg::RIF_DB_IDLE: begin
        if (dreg_evt_i.transmit_strobe) begin
          db_state_d = rif_pkg::RIF_DB_TX;
        end
      end
      rif_pkg::RIF_DB_TX: begin
        db_set = dreg_evt_i.tx_space;
        if (dreg_evt_i.idle_strobe) begin
          db_state_d = rif_pkg::RIF_DB_IDLE;
        end
      end
      rif_pkg::RIF_DB_STAT2: begin
        db_set = 1'b1;
        db_state_d = rif_pkg::RIF_DB_IDLE;
      end
      default: begin
        db_state_d = rif_pkg::RIF_DB_IDLE;
      end
    endcase
    if (dreg_evt_i.append_status && dreg_evt_i.status1_read) begin
      db_state_d = rif_pkg::RIF_DB_STAT2;
    end
    if (dreg_evt_i.rx_byte_ready) begin
      db_set = 1'b1;
    end
    db_flag_d = db_flag_q;
    if (wr_tctl && !reg_wdata_i[rif_pkg::RIF_BIT_DATA_BYTE_FLAG]) begin
      db_flag_d = 1'b0;
    end
    if (db_set) begin
      db_flag_d = 1'b1;
    end
    db_en_d = wr_en0 ? reg_wdata_i[rif_pkg::RIF_BIT_DATA_BYTE_IRQ_ENABLE] : db_en_q;
  end

  // Data-byte registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      db_state_q <= rif_pkg::RIF_DB_IDLE;
      db_flag_q <= rif_pkg::RIF_RST_BIT;
      db_en_q <= rif_pkg::RIF_RST_BIT;
    end else begin
      db_state_q <= db_state_d;
      db_flag_q <= db_flag_d;
      db_en_q <= db_en_d;
    end
  end

  // ************************************************************
  // Interrupt requests and summary status
  // ************************************************************

  // Requests, sticky status cleared by read, set wins
  always_comb begin
    db_irq_d = db_flag_d && db_en_d;
    radio_irq_d = cpu_flag_d && radio_en_d;
    stat_d = stat_q;
    if (rd_stat) begin
      stat_d = rif_pkg::RIF_RST_IRQ_STATUS;
    end
    if (db_set) begin
      stat_d[rif_pkg::RIF_BIT_STAT_DATA_BYTE] = 1'b1;
    end
    if (cpu_set) begin
      stat_d[rif_pkg::RIF_BIT_STAT_RADIO] = 1'b1;
    end
    imask_d = wr_imask ? reg_wdata_i[1:0] : imask_q;
    irq_d = |(stat_d & imask_d);
  end

  // Request registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      stat_q <= rif_pkg::RIF_RST_IRQ_STATUS;
      imask_q <= rif_pkg::RIF_RST_IRQ_MASK;
      db_irq_q <= rif_pkg::RIF_RST_BIT;
      radio_irq_q <= rif_pkg::RIF_RST_BIT;
      irq_q <= rif_pkg::RIF_RST_BIT;
    end else begin
      stat_q <= stat_d;
      imask_q <= imask_d;
      db_irq_q <= db_irq_d;
      radio_irq_q <= radio_irq_d;
      irq_q <= irq_d;
    end
  end

  // ************************************************************
  // Read data path
  // ************************************************************

  // Read mux, unmapped addresses read zero
  always_comb begin
    rdata_d = rif_pkg::RIF_RST_READ_DATA;
    if (reg_rd_i) begin
      case (reg_addr_i)
        rif_pkg::RIF_ADDR_EVENT_FLAGS: rdata_d = flags_q;
        rif_pkg::RIF_ADDR_EVENT_MASK: rdata_d = mask_q;
        rif_pkg::RIF_ADDR_TIMER_CTL: rdata_d[rif_pkg::RIF_BIT_DATA_BYTE_FLAG] = db_flag_q;
        rif_pkg::RIF_ADDR_IRQ_EN_ZERO: rdata_d[rif_pkg::RIF_BIT_DATA_BYTE_IRQ_ENABLE] = db_en_q;
        rif_pkg::RIF_ADDR_IRQ_EN_TWO: rdata_d[rif_pkg::RIF_BIT_RADIO_IRQ_ENABLE] = radio_en_q;
        rif_pkg::RIF_ADDR_CPU_RADIO_FLAG: rdata_d[rif_pkg::RIF_BIT_CPU_RADIO_FLAG] = cpu_flag_q;
        rif_pkg::RIF_ADDR_IRQ_STATUS: rdata_d[1:0] = stat_q;
        rif_pkg::RIF_ADDR_IRQ_MASK: rdata_d[1:0] = imask_q;
        default: rdata_d = rif_pkg::RIF_RST_READ_DATA;
      endcase
    end
  end

  // Read data register, valid one cycle after strobe only
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_q <= rif_pkg::RIF_RST_READ_DATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata_o = rdata_q;
  assign data_byte_irq_o = db_irq_q;
  assign radio_irq_o = radio_irq_q;
  assign irq_o = irq_q;

endmodule : rif_top

`default_nettype wire

/* core/rif_pkg.sv */
// Constants, field layouts and carrier types of the radio interrupt flag block.
// Assumes byte-wide special registers on an 8-bit address space.
package rif_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] RIF_ADDR_EVENT_MASK = 8'h91;
  localparam logic [7:0] RIF_ADDR_EVENT_FLAGS = 8'hE9;
  localparam logic [7:0] RIF_ADDR_TIMER_CTL = 8'h88;
  localparam logic [7:0] RIF_ADDR_IRQ_EN_ZERO = 8'hA8;
  localparam logic [7:0] RIF_ADDR_IRQ_EN_TWO = 8'h9A;
  localparam logic [7:0] RIF_ADDR_CPU_RADIO_FLAG = 8'h98;
  localparam logic [7:0] RIF_ADDR_IRQ_STATUS = 8'hF0;
  localparam logic [7:0] RIF_ADDR_IRQ_MASK = 8'hF1;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int RIF_BIT_TX_UNDERFLOW = 7;
  localparam int RIF_BIT_RX_OVERFLOW = 6;
  localparam int RIF_BIT_RX_TIMEOUT = 5;
  localparam int RIF_BIT_PACKET_DONE = 4;
  localparam int RIF_BIT_CARRIER_SENSE = 3;
  localparam int RIF_BIT_PREAMBLE_QUALITY = 2;
  localparam int RIF_BIT_CLEAR_CHANNEL = 1;
  localparam int RIF_BIT_SYNC_DETECTED = 0;
  localparam int RIF_BIT_DATA_BYTE_FLAG = 1;
  localparam int RIF_BIT_DATA_BYTE_IRQ_ENABLE = 0;
  localparam int RIF_BIT_RADIO_IRQ_ENABLE = 0;
  localparam int RIF_BIT_CPU_RADIO_FLAG = 0;
  localparam int RIF_BIT_STAT_DATA_BYTE = 0;
  localparam int RIF_BIT_STAT_RADIO = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RIF_RST_EVENT_MASK = 8'h00;
  localparam logic [7:0] RIF_RST_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] RIF_RST_READ_DATA = 8'h00;
  localparam logic [1:0] RIF_RST_IRQ_STATUS = 2'h0;
  localparam logic [1:0] RIF_RST_IRQ_MASK = 2'h0;
  localparam logic RIF_RST_BIT = 1'b0;

  // Radio event condition levels, bit order equals the flag register
  typedef struct packed {
    logic tx_underflow;
    logic rx_overflow;
    logic rx_timeout;
    logic packet_done;
    logic carrier_sense;
    logic preamble_quality;
    logic clear_channel;
    logic sync_detected;
  } rif_evt_t;

  // Events around the one-byte radio data register
  typedef struct packed {
    logic rx_byte_ready;
    logic tx_space;
    logic transmit_strobe;
    logic idle_strobe;
    logic append_status;
    logic status1_read;
  } rif_dreg_t;

  // Data-byte sequencing, Gray coded
  typedef enum logic [1:0] {
    RIF_DB_IDLE = 2'b00,
    RIF_DB_TX = 2'b01,
    RIF_DB_STAT2 = 2'b11
  } rif_db_state_t;

endpackage : rif_pkg

/* verification/rif_cpu_model.sv */
// CPU model: byte writes and reads on the register port.
// Assumes read data one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module rif_cpu_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // Idle bus
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d; // Stale data not held
  endtask : wr
  // One-cycle read strobe, data taken in the next cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask : rd
endmodule : rif_cpu_model
`default_nettype wire

/* verification/rif_top_asserts.sv */
// Checker on the ports of the radio interrupt flag block.
// Assumes one clock domain with synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module rif_top_asserts (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire rif_pkg::rif_evt_t evt_cond_i,
  input wire rif_pkg::rif_dreg_t dreg_evt_i,
  input wire logic data_byte_irq_o,
  input wire logic radio_irq_o,
  input wire logic irq_o
);
  logic [7:0] evt_q, evt_d, rise;
  logic [2:0] hist_q, hist_d;
  logic fl_rd, rf_set, rf_clr, db_clr;
  logic [7:0] mask_sh_q, mask_sh_d;
  // Condition history, data-byte cause history, last written mask
  always_comb begin
    evt_d = srst_i ? 8'h00 : evt_cond_i;
    mask_sh_d = srst_i ? 8'h00 : ((reg_wr_i && reg_addr_i == rif_pkg::RIF_ADDR_EVENT_MASK) ? reg_wdata_i : mask_sh_q);
    hist_d = srst_i ? 3'h0 : {hist_q[1:0], dreg_evt_i.rx_byte_ready | dreg_evt_i.tx_space
      | dreg_evt_i.status1_read | (reg_wr_i && reg_addr_i == rif_pkg::RIF_ADDR_IRQ_EN_ZERO)};
  end
  always_ff @(posedge ref_clk_i) begin
    evt_q <= evt_d;
    hist_q <= hist_d;
    mask_sh_q <= mask_sh_d;
  end
  // Decoded causes
  assign rise = evt_cond_i & ~evt_q;
  assign fl_rd = reg_rd_i && reg_addr_i == rif_pkg::RIF_ADDR_EVENT_FLAGS;
  assign rf_set = (|rise) || (reg_wr_i && reg_addr_i == rif_pkg::RIF_ADDR_IRQ_EN_TWO);
  assign rf_clr = reg_wr_i && (reg_addr_i == rif_pkg::RIF_ADDR_CPU_RADIO_FLAG
    || reg_addr_i == rif_pkg::RIF_ADDR_IRQ_EN_TWO);
  assign db_clr = reg_wr_i && (reg_addr_i == rif_pkg::RIF_ADDR_TIMER_CTL
    || reg_addr_i == rif_pkg::RIF_ADDR_IRQ_EN_ZERO);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  rst_outs_a:
    assert property (disable iff (1'b0) srst_i |=> !irq_o && !radio_irq_o && !data_byte_irq_o && reg_rdata_o == 8'h00)
    else $error("outputs not cleared by reset");
  mask_rb_a:
    assert property (reg_rd_i && reg_addr_i == rif_pkg::RIF_ADDR_EVENT_MASK
      |=> reg_rdata_o == $past(mask_sh_q))
    else $error("mask readback differs");
  rise_flag_a:
    assert property ((|rise) ##2 fl_rd |=> (reg_rdata_o & $past(rise, 3)) == $past(rise, 3))
    else $error("rising condition left no flag");
  done_pair_a:
    assert property ((rise[7] || rise[6]) ##2 fl_rd |=> reg_rdata_o[4])
    else $error("packet done missing with overflow");
  radio_rise_a:
    assert property ($rose(radio_irq_o) |-> $past(rf_set) || $past(rf_set, 2))
    else $error("radio request without cause");
  radio_fall_a:
    assert property ($fell(radio_irq_o) |-> $past(rf_clr) || $past(rf_clr, 2) || $past(srst_i))
    else $error("radio request dropped unasked");
  db_rise_a:
    assert property ($rose(data_byte_irq_o) |-> hist_q != 3'h0)
    else $error("data byte request without cause");
  db_fall_a:
    assert property ($fell(data_byte_irq_o) |-> $past(db_clr) || $past(db_clr, 2) || $past(srst_i))
    else $error("data byte request dropped unasked");
  c_flag: cover property ((|rise) ##2 fl_rd);
  c_radio: cover property ($rose(radio_irq_o));
  c_data: cover property ($rose(data_byte_irq_o));
endmodule : rif_top_asserts
bind rif_top rif_top_asserts u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .evt_cond_i(evt_cond_i), .dreg_evt_i(dreg_evt_i), .data_byte_irq_o(data_byte_irq_o),
  .radio_irq_o(radio_irq_o), .irq_o(irq_o));
`default_nettype wire

/* verification/radio_interrupt_flags_bench.sv */
// Bench of the radio interrupt flag block: registers, events, data byte.
// Assumes the CPU model as bus master and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module radio_interrupt_flags_bench;
  localparam logic [7:0] AF = rif_pkg::RIF_ADDR_EVENT_FLAGS;
  localparam logic [7:0] AM = rif_pkg::RIF_ADDR_EVENT_MASK;
  localparam logic [7:0] CF = rif_pkg::RIF_ADDR_CPU_RADIO_FLAG;
  localparam logic [7:0] DF = rif_pkg::RIF_ADDR_TIMER_CTL;
  localparam logic [7:0] E0 = rif_pkg::RIF_ADDR_IRQ_EN_ZERO;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr, wdata, rdata, v;
  logic wr, rd, db_irq, rf_irq, irq;
  rif_pkg::rif_evt_t evt = '0;
  rif_pkg::rif_dreg_t dreg = '0;
  int bad_count = 0;
  int checks = 0;
  // Clock
  always #5 ref_clk_i = ~ref_clk_i;
  rif_cpu_model u_cpu (.clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  rif_top u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .evt_cond_i(evt), .dreg_evt_i(dreg),
    .data_byte_irq_o(db_irq), .radio_irq_o(rf_irq), .irq_o(irq));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_cpu.rd(a, v);
    chk($sformatf("reg %h", a), v, e);
  endtask : rchk
  // One-cycle pulse on a data register event bit
  task automatic pulse(input int b);
    @(posedge ref_clk_i);
    dreg[b] <= 1'b1;
    @(posedge ref_clk_i);
    dreg[b] <= 1'b0;
    tick(2);
  endtask : pulse
  // Reset values, unmapped read, mask write, write-one keeps flags clear
  task automatic t_regs();
    rchk(AF, 8'h00);
    rchk(AM, 8'h00);
    rchk(8'h00, 8'h00);
    u_cpu.wr(AM, 8'hA5);
    rchk(AM, 8'hA5);
    u_cpu.wr(AF, 8'hFF);
    rchk(AF, 8'h00);
    u_cpu.wr(AM, 8'h00);
  endtask : t_regs
  // Each condition edge sets its own flag; a held level does not re-set
  task automatic t_events();
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      e = 8'h01 << i;
      e[4] = e[4] | (i > 5);
      @(posedge ref_clk_i);
      evt <= 8'h01 << i;
      tick(1);
      rchk(AF, e);
      u_cpu.wr(AF, 8'h00);
      rchk(AF, 8'h00);
      @(posedge ref_clk_i);
      evt <= 8'h00;
    end
  endtask : t_events
  // Mask gating, sticky CPU flag, summary status and mask
  task automatic t_radio();
    u_cpu.wr(AM, 8'h01);
    u_cpu.wr(rif_pkg::RIF_ADDR_IRQ_EN_TWO, 8'h01);
    u_cpu.wr(rif_pkg::RIF_ADDR_IRQ_MASK, 8'h02);
    evt <= 8'h02;
    tick(3);
    chk("radio", 8'(rf_irq), 8'h00);
    @(posedge ref_clk_i);
    evt <= 8'h03;
    tick(3);
    chk("radio", 8'(rf_irq), 8'h01);
    chk("irq", 8'(irq), 8'h01);
    u_cpu.wr(rif_pkg::RIF_ADDR_IRQ_EN_TWO, 8'h00);
    tick(1);
    chk("radio", 8'(rf_irq), 8'h00);
    u_cpu.wr(rif_pkg::RIF_ADDR_IRQ_EN_TWO, 8'h01);
    tick(1);
    chk("radio", 8'(rf_irq), 8'h01);
    u_cpu.wr(AF, 8'h00);
    tick(1);
    chk("radio", 8'(rf_irq), 8'h01);
    rchk(rif_pkg::RIF_ADDR_IRQ_STATUS, 8'h02);
    tick(1);
    chk("irq", 8'(irq), 8'h00);
    u_cpu.wr(CF, 8'h00);
    tick(1);
    chk("radio", 8'(rf_irq), 8'h00);
    @(posedge ref_clk_i);
    evt <= 8'h00;
  endtask : t_radio
  // Data byte flag: transmit gating, receive, enable, status byte two
  task automatic t_data();
    u_cpu.wr(E0, 8'h01);
    pulse(4);
    chk("db", 8'(db_irq), 8'h00);
    pulse(3); // Transmit strobe first
    pulse(4);
    chk("db", 8'(db_irq), 8'h01);
    rchk(DF, 8'h02);
    rchk(rif_pkg::RIF_ADDR_IRQ_STATUS, 8'h01);
    u_cpu.wr(DF, 8'h00);
    tick(1);
    chk("db", 8'(db_irq), 8'h00);
    pulse(5);
    chk("db", 8'(db_irq), 8'h01);
    u_cpu.wr(E0, 8'h00);
    tick(1);
    chk("db", 8'(db_irq), 8'h00);
    u_cpu.wr(E0, 8'h01);
    tick(1);
    chk("db", 8'(db_irq), 8'h01);
    u_cpu.wr(DF, 8'h00);
    pulse(2);
    pulse(4);
    chk("db", 8'(db_irq), 8'h00);
    @(posedge ref_clk_i);
    dreg.append_status <= 1'b1;
    pulse(0);
    chk("db", 8'(db_irq), 8'h01);
    u_cpu.wr(DF, 8'h00);
    tick(1);
    chk("db", 8'(db_irq), 8'h00);
  endtask : t_data
  // Mid-run reset clears requests; a condition high at release flags
  task automatic t_reset();
    pulse(5);
    chk("db", 8'(db_irq), 8'h01);
    @(posedge ref_clk_i);
    evt <= 8'h01;
    srst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    tick(1);
    chk("outs", {5'h00, db_irq, rf_irq, irq}, 8'h00);
    rchk(AM, 8'h00);
    rchk(AF, 8'h01);
  endtask : t_reset
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    tick(1);
    t_regs();
    t_events();
    t_radio();
    t_data();
    t_reset();
    give_verdict();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    give_verdict();
  end
endmodule : radio_interrupt_flags_bench
`default_nettype wire
